// [verilog/pwr_seq_defines.vh]
// Constants for the power-down sequencer
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH
`define PD_PORTA_W 8
`define PD_INT_W 8
`define PD_SST_CYCLES 11'h400
`define PD_SST_W 11
`define PD_MODE_RUN 5'h01
`define PD_MODE_SLP0 5'h02
`define PD_MODE_SLP1 5'h04
`define PD_MODE_IDL0 5'h08
`define PD_MODE_IDL1 5'h10
`endif

// [verilog/startup_timer.v]
// Shared oscillator startup counter, fast crystal first then slow crystal
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defines.vh"
module startup_timer (
    input wire i_ref_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_fast_tick,
    input wire i_slow_tick,
    input wire i_fast_start,
    input wire i_slow_start,
    output reg o_fast_ready,
    output reg o_slow_ready
);
    reg [`PD_SST_W-1:0] cnt_r;
    reg fast_pend_r;
    reg slow_pend_r;
    wire busy_fast = fast_pend_r & ~o_fast_ready;
    // One counter only: the slow crystal waits its turn until the fast one is stable
    wire busy_slow = slow_pend_r & ~o_slow_ready & ~busy_fast; // RULE20
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_r <= {`PD_SST_W{1'b0}};
            fast_pend_r <= 1'b0;
            slow_pend_r <= 1'b0;
            o_fast_ready <= 1'b0;
            o_slow_ready <= 1'b0;
        end else if (i_ce) begin
            if (i_fast_start) begin
                fast_pend_r <= 1'b1;
                o_fast_ready <= 1'b0;
                cnt_r <= {`PD_SST_W{1'b0}};
            end else if (busy_fast) begin
                if (i_fast_tick) begin
                    if (cnt_r == `PD_SST_CYCLES - 11'h001) begin
                        o_fast_ready <= 1'b1;
                        fast_pend_r <= 1'b0;
                        cnt_r <= {`PD_SST_W{1'b0}};
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
            end else if (busy_slow) begin
                if (i_slow_tick) begin
                    if (cnt_r == `PD_SST_CYCLES - 11'h001) begin
                        o_slow_ready <= 1'b1;
                        slow_pend_r <= 1'b0;
                        cnt_r <= {`PD_SST_W{1'b0}};
                    end else begin
                        cnt_r <= cnt_r + 11'h001;
                    end
                end
            end
            if (i_slow_start) begin
                slow_pend_r <= 1'b1;
                o_slow_ready <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/power_down_mode_and_wakeup.v]
// Power-down mode selection, clock gating and wake-up sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defines.vh"
// Operation
// RULE1: Halt, idle off, no watchdog/detector: sleep_all_off
// RULE2: sleep_all_off stops system, watchdog, time-base clocks
// RULE3: sleep_all_off clears and holds watchdog stopped
// RULE4: Halt, idle off, watchdog/detector on: sleep_sub_on
// RULE5: sleep_sub_on keeps sub clock; watchdog cleared, runs (code runs it only when i_wdt_src_sub is set)
// RULE6: Halt, idle on, sysclk off: idle_sub_only
// RULE7: idle_sub_only stops system clock only
// RULE8: idle_sub_only: sub watchdog runs, system watchdog stops
// RULE9: Halt, idle on, sysclk on: idle_sysclk_on
// RULE10: idle_sysclk_on: watchdog cleared then keeps counting
// RULE11: Memory, registers and ports retained while down
// RULE12: Entry sets power-down flag, clears timeout flag
// RULE13: Wake on reset, port edge, interrupt, overflow
// RULE14: Overflow wake sets timeout, resets PC/SP only
// RULE15: Power-down flag cleared by reset or clear-watchdog
// RULE16: Enabled Port A falling edge wakes, resume next
// RULE17: Disabled/stack-full interrupt resumes next, stays pending
// RULE18: Enabled interrupt with stack room: normal response
// RULE19: Interrupt flagged before entry cannot wake
// RULE20: Crystals share startup timer, slow after fast
// RULE21: Wake from sleep_all_off runs after fast ready
// RULE22: Fast wake from sleep_sub_on may use sub clock
// RULE23: Fast wake runs sub clock for 1024 cycles
module power_down_mode_and_wakeup (
    input wire i_ref_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_halt_exec,
    input wire i_clr_wdt_exec,
    input wire i_idle_select,
    input wire i_sysclk_in_idle,
    input wire i_fast_wake_enable,
    input wire i_sys_is_fast_crystal,
    input wire i_wdt_enabled,
    input wire i_wdt_src_sub,
    input wire i_lvd_enabled,
    input wire i_wdt_overflow,
    input wire [`PD_PORTA_W-1:0] i_porta,
    input wire [`PD_PORTA_W-1:0] i_porta_wake_enable,
    input wire [`PD_INT_W-1:0] i_int_req,
    input wire [`PD_INT_W-1:0] i_int_enable,
    input wire i_stack_full,
    input wire i_fast_tick,
    input wire i_slow_tick,
    input wire i_slow_xtal_used,
    output reg [4:0] o_mode,
    output reg o_sysclk_en,
    output reg o_timebase_clk_en,
    output reg o_sub_clk_en,
    output reg o_wdt_clk_en,
    output reg o_wdt_clear,
    output reg o_power_down_flag,
    output reg o_watchdog_timeout_flag,
    output reg o_cpu_run,
    output reg o_sys_on_sub_clk,
    output reg o_high_osc_ready,
    output wire o_slow_osc_ready,
    output reg o_pc_sp_reset,
    output reg o_int_service,
    output reg [`PD_INT_W-1:0] o_int_pending,
    output reg o_resume_next
);
    localparam [2:0] WK_IDLE = 3'h1;
    localparam [2:0] WK_SST = 3'h2;
    localparam [2:0] WK_FAST = 3'h4;

    reg [2:0] wk_r;
    reg [`PD_PORTA_W-1:0] porta_q_r;
    reg [`PD_INT_W-1:0] int_mask_r;
    reg fast_start_r;
    reg slow_start_r;
    wire fast_ready;
    wire down = (o_mode != `PD_MODE_RUN);
    wire [`PD_PORTA_W-1:0] pa_fall = porta_q_r & ~i_porta & i_porta_wake_enable; // RULE16
    // Interrupts already set at entry are masked out of the wake sources
    wire [`PD_INT_W-1:0] int_wake = i_int_req & ~int_mask_r; // RULE19
    wire int_hit = |int_wake;
    wire serve = int_hit & (|(int_wake & i_int_enable)) & ~i_stack_full;
    wire wake_any = (|pa_fall) | int_hit | i_wdt_overflow; // RULE13
    reg [4:0] mode_nxt;

    always @* begin
        mode_nxt = `PD_MODE_SLP0;
        if (i_idle_select) begin
            mode_nxt = i_sysclk_in_idle ? `PD_MODE_IDL1 : `PD_MODE_IDL0; // RULE6 RULE9
        end else if (i_wdt_enabled | i_lvd_enabled) begin
            mode_nxt = `PD_MODE_SLP1; // RULE4
        end else begin
            mode_nxt = `PD_MODE_SLP0; // RULE1
        end
    end

    startup_timer u_sst (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_fast_tick(i_fast_tick),
        .i_slow_tick(i_slow_tick),
        .i_fast_start(fast_start_r),
        .i_slow_start(slow_start_r),
        .o_fast_ready(fast_ready),
        .o_slow_ready(o_slow_osc_ready)
    );

    // Clock gating follows the mode; state elsewhere is simply not touched, so it is kept
    always @* begin
        o_sysclk_en = 1'b1;
        o_timebase_clk_en = 1'b1;
        o_sub_clk_en = 1'b1;
        o_wdt_clk_en = i_wdt_enabled;
        case (o_mode)
            `PD_MODE_SLP0: begin
                o_sysclk_en = 1'b0; // RULE2
                o_timebase_clk_en = 1'b0;
                o_sub_clk_en = 1'b0;
                o_wdt_clk_en = 1'b0; // RULE3
            end
            `PD_MODE_SLP1: begin
                o_sysclk_en = 1'b0; // RULE5
                o_timebase_clk_en = 1'b0;
                o_wdt_clk_en = i_wdt_enabled & i_wdt_src_sub;
            end
            `PD_MODE_IDL0: begin
                o_sysclk_en = 1'b0; // RULE7
                o_wdt_clk_en = i_wdt_enabled & i_wdt_src_sub; // RULE8
            end
            `PD_MODE_IDL1: begin
                o_wdt_clk_en = i_wdt_enabled; // RULE10
            end
            default: begin
                o_sysclk_en = 1'b1;
            end
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            // External reset is the full system reset, also when it wakes the device
            o_mode <= `PD_MODE_RUN; // RULE14
            wk_r <= WK_IDLE;
            porta_q_r <= {`PD_PORTA_W{1'b1}};
            int_mask_r <= {`PD_INT_W{1'b0}};
            fast_start_r <= 1'b0;
            slow_start_r <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_power_down_flag <= 1'b0; // RULE15
            o_watchdog_timeout_flag <= 1'b0;
            o_cpu_run <= 1'b1;
            o_sys_on_sub_clk <= 1'b0;
            o_high_osc_ready <= 1'b1;
            o_pc_sp_reset <= 1'b0;
            o_int_service <= 1'b0;
            o_int_pending <= {`PD_INT_W{1'b0}};
            o_resume_next <= 1'b0;
        end else if (i_ce) begin
            porta_q_r <= i_porta;
            fast_start_r <= 1'b0;
            slow_start_r <= 1'b0;
            o_wdt_clear <= 1'b0;
            o_pc_sp_reset <= 1'b0;
            o_int_service <= 1'b0;
            o_resume_next <= 1'b0;
            // Pending requests drop only when the core withdraws the request; servicing does not clear them
            o_int_pending <= o_int_pending & i_int_req; // RULE17
            if (i_clr_wdt_exec & ~i_halt_exec) begin
                o_power_down_flag <= 1'b0; // RULE15
            end
            if (!down && wk_r == WK_IDLE) begin
                if (i_halt_exec) begin
                    o_mode <= mode_nxt; // RULE11
                    o_cpu_run <= 1'b0;
                    o_wdt_clear <= 1'b1; // RULE3 RULE5 RULE8 RULE10
                    o_power_down_flag <= 1'b1; // RULE12 RULE15
                    o_watchdog_timeout_flag <= 1'b0; // RULE12
                    int_mask_r <= i_int_req; // RULE19
                end
            end else if (down && wake_any) begin
                o_mode <= `PD_MODE_RUN;
                if (i_wdt_overflow) begin
                    o_watchdog_timeout_flag <= 1'b1; // RULE14
                    o_pc_sp_reset <= 1'b1;
                end else if (serve) begin
                    o_int_service <= 1'b1; // RULE18
                end else begin
                    o_resume_next <= 1'b1; // RULE16 RULE17
                    o_int_pending <= o_int_pending | int_wake; // RULE17
                end
                if ((o_mode == `PD_MODE_SLP0 || o_mode == `PD_MODE_SLP1) && i_sys_is_fast_crystal) begin
                    // Fast crystal was off, so it must restart and stabilise
                    o_high_osc_ready <= 1'b0;
                    fast_start_r <= 1'b1;
                    slow_start_r <= (o_mode == `PD_MODE_SLP0) & i_slow_xtal_used; // RULE20
                    if (o_mode == `PD_MODE_SLP1 && i_fast_wake_enable) begin
                        o_sys_on_sub_clk <= 1'b1; // RULE22 RULE23
                        o_cpu_run <= 1'b1;
                        wk_r <= WK_FAST;
                    end else begin
                        wk_r <= WK_SST; // RULE21
                    end
                end else begin
                    o_cpu_run <= 1'b1;
                end
            end else begin
                case (wk_r)
                    WK_SST: begin
                        if (fast_ready && !fast_start_r) begin
                            o_high_osc_ready <= 1'b1; // RULE21
                            o_cpu_run <= 1'b1;
                            wk_r <= WK_IDLE;
                        end
                    end
                    WK_FAST: begin
                        if (fast_ready && !fast_start_r) begin
                            o_high_osc_ready <= 1'b1; // RULE23
                            o_sys_on_sub_clk <= 1'b0;
                            wk_r <= WK_IDLE;
                        end
                    end
                    default: begin
                        wk_r <= WK_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [test/pd_seq_chk.sv]
// Port assertions for the power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module pd_seq_chk (
    input wire i_ref_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_halt_exec,
    input wire i_clr_wdt_exec,
    input wire i_idle_select,
    input wire i_sysclk_in_idle,
    input wire i_wdt_enabled,
    input wire i_lvd_enabled,
    input wire i_wdt_overflow,
    input wire [4:0] o_mode,
    input wire o_sysclk_en,
    input wire o_timebase_clk_en,
    input wire o_sub_clk_en,
    input wire o_wdt_clk_en,
    input wire o_wdt_clear,
    input wire o_power_down_flag,
    input wire o_watchdog_timeout_flag,
    input wire o_cpu_run,
    input wire o_sys_on_sub_clk,
    input wire o_high_osc_ready,
    input wire o_pc_sp_reset
);
    // A halt is only taken from a settled run state; during startup waits it is refused
    wire take = i_ce && (o_mode == 5'h01) && o_cpu_run && o_high_osc_ready && i_halt_exec;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    a_enter_sleep_off: assert property (take && !i_idle_select && !i_wdt_enabled && !i_lvd_enabled |=> o_mode == 5'h02)
        else $error("halt did not enter sleep_all_off");
    a_enter_sleep_sub: assert property (take && !i_idle_select && (i_wdt_enabled || i_lvd_enabled) |=> o_mode == 5'h04)
        else $error("halt did not enter sleep_sub_on");
    a_enter_idle_sub: assert property (take && i_idle_select && !i_sysclk_in_idle |=> o_mode == 5'h08)
        else $error("halt did not enter idle_sub_only");
    a_enter_idle_sys: assert property (take && i_idle_select && i_sysclk_in_idle |=> o_mode == 5'h10)
        else $error("halt did not enter idle_sysclk_on");
    a_sleep_off_gate: assert property (o_mode == 5'h02 |-> !o_sysclk_en && !o_timebase_clk_en && !o_wdt_clk_en)
        else $error("clocks running in sleep_all_off");
    a_sleep_sub_gate: assert property (o_mode == 5'h04 |-> !o_sysclk_en && !o_timebase_clk_en && o_sub_clk_en)
        else $error("wrong clock gating in sleep_sub_on");
    a_idle_gate: assert property (o_mode == 5'h08 || o_mode == 5'h10 |-> o_timebase_clk_en && o_sub_clk_en && o_sysclk_en == o_mode[4])
        else $error("wrong clock gating in idle");
    a_entry_flags: assert property (take |=> o_power_down_flag && !o_watchdog_timeout_flag && o_wdt_clear && !o_cpu_run)
        else $error("entry flags wrong");
    a_overflow_wake: assert property (i_ce && o_mode != 5'h01 && i_wdt_overflow |=> o_pc_sp_reset && o_watchdog_timeout_flag)
        else $error("overflow wake not signalled");
    a_clear_pdf: assert property (i_ce && i_clr_wdt_exec && !i_halt_exec |=> !o_power_down_flag)
        else $error("clear-watchdog left power-down flag");
    a_run_needs_osc: assert property (o_cpu_run && !o_sys_on_sub_clk |-> o_high_osc_ready)
        else $error("execution before fast oscillator ready");
    c_idle_sys: cover property (take && i_idle_select && i_sysclk_in_idle);
    c_overflow: cover property (o_mode != 5'h01 && i_wdt_overflow);
    c_fast_wake: cover property ($rose(o_cpu_run) && o_sys_on_sub_clk);
endmodule
bind power_down_mode_and_wakeup pd_seq_chk u_chk (.*);
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the power-down sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_halt_exec = 1'b0, i_clr_wdt_exec = 1'b0;
    logic i_idle_select = 1'b0, i_sysclk_in_idle = 1'b0, i_fast_wake_enable = 1'b0, i_sys_is_fast_crystal = 1'b0;
    logic i_wdt_enabled = 1'b0, i_wdt_src_sub = 1'b0, i_lvd_enabled = 1'b0, i_wdt_overflow = 1'b0, i_stack_full = 1'b0;
    logic i_fast_tick = 1'b0, i_slow_tick = 1'b0, i_slow_xtal_used = 1'b0;
    logic [7:0] i_porta = 8'hFF, i_porta_wake_enable = 8'h00, i_int_req = 8'h00, i_int_enable = 8'h00;
    logic [4:0] o_mode, em;
    logic o_sysclk_en, o_timebase_clk_en, o_sub_clk_en, o_wdt_clk_en, o_wdt_clear, o_power_down_flag;
    logic o_watchdog_timeout_flag, o_cpu_run, o_sys_on_sub_clk, o_high_osc_ready, o_slow_osc_ready;
    logic o_pc_sp_reset, o_int_service, o_resume_next, fast, rs, fw;
    logic [7:0] o_int_pending, rnd = 8'h46;
    int n_mismatch = 0, checks_done = 0, ticks = 0, it, kind, b, k;
    power_down_mode_and_wakeup uut (.*);
    initial forever #50 i_ref_clk = ~i_ref_clk;
    // Fast ticks every other cycle keep the 1024-tick wait short but real
    always @(negedge i_ref_clk) i_fast_tick <= ~i_fast_tick;
    always @(negedge i_ref_clk) i_slow_tick <= rnd[0];
    // Restarts at the wake pulse, the same edge at which the startup count is armed
    always @(posedge i_ref_clk) ticks <= (o_pc_sp_reset | o_int_service | o_resume_next) ? 0 : ticks + int'(i_fast_tick);
    function automatic [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task step;
        @(negedge i_ref_clk);
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #(100 * 60000);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (4) step;
        i_srst = 1'b0;
        step;
        chk({o_mode, o_cpu_run, o_high_osc_ready, o_power_down_flag}, {5'h01, 3'b110});
        for (it = 0; it < 16; it++) begin
            rnd = lfsr(rnd);
            kind = it / 4;
            b = rnd[6:4];
            i_idle_select = it[1];
            i_sysclk_in_idle = it[0];
            {i_wdt_enabled, i_lvd_enabled} = (it % 4 != 0) ? {rnd[1], ~rnd[1]} : 2'b00;
            {i_sys_is_fast_crystal, i_fast_wake_enable, i_wdt_src_sub, i_slow_xtal_used} = rnd[3:0];
            fast = i_sys_is_fast_crystal;
            em = it[1] ? (it[0] ? 5'h10 : 5'h08) : (it[0] ? 5'h04 : 5'h02);
            i_int_req = (kind == 0) ? (8'h01 << b) : 8'h00;
            i_porta_wake_enable = 8'h01 << b;
            i_halt_exec = 1'b1;
            step;
            i_halt_exec = 1'b0;
            chk(o_mode, em);
            chk({o_power_down_flag, o_watchdog_timeout_flag, o_wdt_clear, o_cpu_run}, 4'b1010);
            chk({o_sysclk_en, o_timebase_clk_en, o_sub_clk_en & (em != 5'h02)},
                em[4] ? 3'b111 : em[3] ? 3'b011 : {2'b00, em[2]});
            chk(o_wdt_clk_en, i_wdt_enabled & (i_wdt_src_sub | em[4]));
            // A disabled pin falling, and in kind 0 a flag raised before entry, must both be ignored
            i_porta[b ^ 1] = 1'b0;
            repeat (3) step;
            chk(o_mode, em);
            i_porta = 8'hFF;
            step;
            i_int_enable = (kind == 2 || (kind == 1 && rnd[7])) ? (8'h01 << b) : 8'h00;
            i_stack_full = kind == 1 && rnd[7];
            i_wdt_overflow = kind == 3;
            i_int_req = (kind == 1 || kind == 2) ? (8'h01 << b) : 8'h00;
            if (kind == 0) i_porta[b] = 1'b0;
            // Clock enable low must freeze the wake until it returns
            i_ce = 1'b0;
            step;
            chk({o_mode, o_pc_sp_reset, o_int_service, o_resume_next}, {em, 3'b000});
            i_ce = 1'b1;
            step;
            i_wdt_overflow = 1'b0;
            chk({o_pc_sp_reset, o_int_service, o_resume_next},
                kind == 3 ? 3'b100 : kind == 2 ? 3'b010 : 3'b001);
            chk({o_mode, o_power_down_flag, o_watchdog_timeout_flag}, {5'h01, 1'b1, kind == 3});
            chk(o_int_pending, kind == 1 ? (8'h01 << b) : 8'h00);
            rs = fast && (em == 5'h02 || em == 5'h04);
            fw = i_fast_wake_enable && em == 5'h04;
            chk({o_sys_on_sub_clk, o_cpu_run, o_high_osc_ready}, {rs & fw, !rs | fw, !rs});
            i_porta = 8'hFF;
            i_int_req = 8'h00;
            i_stack_full = 1'b0;
            for (k = 0; k < 3000 && !(o_cpu_run === 1'b1 && o_high_osc_ready === 1'b1); k++) step;
            chk({o_cpu_run, o_high_osc_ready, o_sys_on_sub_clk, o_mode}, {3'b110, 5'h01});
            if (fast && (em == 5'h02 || em == 5'h04)) chk(ticks >= 1024, 1'b1);
            if (fast && em == 5'h02 && i_slow_xtal_used) begin
                // Slow crystal only starts counting once the fast one is stable
                chk(o_slow_osc_ready, 1'b0);
                for (k = 0; k < 1100 && o_slow_osc_ready !== 1'b1; k++) step;
                chk(k > 1000 && o_slow_osc_ready === 1'b1, 1'b1);
            end
            i_clr_wdt_exec = 1'b1;
            step;
            i_clr_wdt_exec = 1'b0;
            chk(o_power_down_flag, 1'b0);
            $display("test %0d done", it);
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
